// ### pkg/wdhw_pkg.sv
// package: constants and types for the watchdog and halt/wake-up block
package wdhw_pkg;
    // register map (byte addresses on the plain register port)
    localparam logic [3:0] WDHW_ADDR_SETUP = 4'h0;
    localparam logic [3:0] WDHW_ADDR_STATUS = 4'h4;
    localparam logic [3:0] WDHW_ADDR_OPTION = 4'h8;
    localparam logic [3:0] WDHW_ADDR_WAKE = 4'hC;
    // setup register layout
    localparam int WDHW_SEL_LSB = 0;
    localparam int WDHW_SEL_W = 3;
    localparam logic [7:0] WDHW_SETUP_RST = 8'h07;
    // status register layout
    localparam int WDHW_PDF_BIT = 4;
    localparam int WDHW_TO_BIT = 5;
    // option register layout
    localparam int WDHW_OPT_EN_BIT = 0;
    localparam int WDHW_OPT_OSC_BIT = 1;
    localparam int WDHW_OPT_DUAL_BIT = 2;
    localparam int WDHW_OPT_RC_BIT = 3;
    localparam logic [7:0] WDHW_OPT_RST = 8'h03;
    localparam logic [7:0] WDHW_WAKE_EN_RST = 8'h00;
    // timing
    localparam int WDHW_SYSDIV = 4;
    localparam int WDHW_PRE_STAGES = 8;
    localparam int WDHW_SEL_STAGES = 7;
    localparam int WDHW_WAKE_TSYS = 1024;
    localparam logic [10:0] WDHW_WAKE_CYC = 11'(WDHW_WAKE_TSYS);
    // power state
    typedef enum logic [2:0] {
        WDHW_RUN = 3'b001,
        WDHW_HALT = 3'b010,
        WDHW_WAKE = 3'b100
    } wdhw_state_t;
endpackage

// ### src/wdhw_top.sv
// module: watchdog timer with halt entry, wake-up and restart sequencing
// Operation
// - clock source: watchdog oscillator or instruction clock
// - disabled watchdog ignores instructions, never times out
// - oscillator path passes fixed divide-by-256
// - select bits pick prescaler ratio two-power code
// - bit 3 and high nibble are plain storage
// - overflow when running: chip reset, expired flag set
// - overflow in halt: warm reset, counter/stack only
// - pin, clear instruction, halt clear the watchdog
// - single-clear option: kick instruction clears each time
// - dual-clear option: both paired kicks needed
// - instruction-clock source stops during halt
// - halt stops system oscillator, watchdog oscillator runs
// - halt keeps memory, registers and port state
// - halt entry clears watchdog, counts from zero
// - halt sets powerdown, clears expired; kick clears powerdown
// - leave halt on reset, interrupt, port edge, overflow
// - per-bit port wake enables; resume next instruction
// - disabled or stack-full interrupt resumes next instruction
// - request pending before halt cannot wake
// - wait 1024 system clocks after wake-up
// - rc mode drives system clock divided by four
// - rc or crystal option drives the system clock
//
// The strobed register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module wdhw_top
    import wdhw_pkg::*;
#(
    parameter int P_WAKE_CYC = WDHW_WAKE_TSYS,
    parameter int P_PORT_W = 8
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    // pins
    input wire logic i_external_clear_pin_n,
    input wire logic i_wdt_osc,
    input wire logic i_clock_timing_in_rc,
    input wire logic i_clock_timing_in_xtal,
    input wire logic [P_PORT_W-1:0] i_port_a,
    output logic o_clock_div4_out,
    output logic o_clock_div4_out_oe,
    // core events
    input wire logic i_watchdog_kick_instr,
    input wire logic i_watchdog_kick_first,
    input wire logic i_watchdog_kick_second,
    input wire logic i_halt_instr,
    input wire logic i_irq_pending,
    input wire logic i_irq_enabled,
    input wire logic i_stack_full,
    // core controls
    output logic o_chip_reset,
    output logic o_warm_reset,
    output logic o_sys_clk_en,
    output logic o_halted,
    output logic o_hold_state,
    output logic o_resume_next,
    output logic o_irq_service,
    // register port
    input wire logic [3:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output logic [7:0] o_reg_rdata
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] pin_sync_q;
    logic [1:0] osc_sync_q;
    logic [P_PORT_W-1:0] pa_s1_q;
    logic [P_PORT_W-1:0] pa_s2_q;
    logic [P_PORT_W-1:0] pa_prev_q;
    logic osc_prev_q;
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pin_sync_q <= 2'b11;
            osc_sync_q <= 2'b00;
            osc_prev_q <= 1'b0;
        end else begin
            pin_sync_q <= {pin_sync_q[0], i_external_clear_pin_n};
            osc_sync_q <= {osc_sync_q[0], i_wdt_osc};
            osc_prev_q <= osc_sync_q[1];
        end
    end
    // port bits reset high, the pulled-up idle level, so no false edge follows reset
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pa_s1_q <= '1;
            pa_s2_q <= '1;
            pa_prev_q <= '1;
        end else begin
            pa_s1_q <= i_port_a;
            pa_s2_q <= pa_s1_q;
            pa_prev_q <= pa_s2_q;
        end
    end
    wire pin_low = !pin_sync_q[1];

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0] setup_q;
    logic [7:0] opt_q;
    logic [7:0] wake_en_q;
    logic to_q;
    logic pdf_q;
    logic rd_q;
    wire wr_setup = i_reg_wr && (i_reg_addr == WDHW_ADDR_SETUP);
    wire wr_opt = i_reg_wr && (i_reg_addr == WDHW_ADDR_OPTION);
    wire wr_wake = i_reg_wr && (i_reg_addr == WDHW_ADDR_WAKE);
    wire rd_setup = (i_reg_addr == WDHW_ADDR_SETUP);
    wire rd_status = (i_reg_addr == WDHW_ADDR_STATUS);
    wire rd_opt = (i_reg_addr == WDHW_ADDR_OPTION);
    wire rd_wake = (i_reg_addr == WDHW_ADDR_WAKE);
    wire opt_en = opt_q[WDHW_OPT_EN_BIT];
    wire opt_osc = opt_q[WDHW_OPT_OSC_BIT];
    wire opt_dual = opt_q[WDHW_OPT_DUAL_BIT];
    wire opt_rc = opt_q[WDHW_OPT_RC_BIT];
    wire [2:0] sel = setup_q[WDHW_SEL_LSB +: WDHW_SEL_W];

    // ------------------------------------------------------------
    // power state and clear sources
    // ------------------------------------------------------------
    wdhw_state_t state_q;
    wdhw_state_t state_d;
    logic [10:0] wake_cnt_q;
    logic kick1_seen_q;
    logic kick2_seen_q;
    logic irq_at_halt_q;
    logic wake_irq_q;
    logic timeout;
    wire in_halt = (state_q == WDHW_HALT);
    wire halt_go = i_halt_instr && (state_q == WDHW_RUN);
    // disabled watchdog turns every related instruction into a no-op
    wire kick_single = opt_en && !opt_dual && i_watchdog_kick_instr;
    wire k1 = kick1_seen_q || i_watchdog_kick_first;
    wire k2 = kick2_seen_q || i_watchdog_kick_second;
    wire kick_dual = opt_en && opt_dual && k1 && k2;
    wire kick = kick_single || kick_dual;
    wire wdt_clear = pin_low || kick || halt_go || timeout;
    // per-bit falling-edge detect, masked by the wake enables
    logic [P_PORT_W-1:0] pa_fall;
    genvar b;
    generate
        for (b = 0; b < P_PORT_W; b++) begin : g_pa_fall
            assign pa_fall[b] = wake_en_q[b] && pa_prev_q[b] && !pa_s2_q[b];
        end
    endgenerate
    wire port_fall = |pa_fall;
    // a request already pending at halt entry is masked out
    wire irq_wake = i_irq_pending && !irq_at_halt_q;
    wire wake_ev = in_halt && (port_fall || irq_wake || timeout);
    wire wake_by_irq = irq_wake && !port_fall && !timeout;

    // paired kicks latch until both are seen, in either order
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            kick1_seen_q <= 1'b0;
            kick2_seen_q <= 1'b0;
        end else if (wdt_clear || !opt_dual) begin
            kick1_seen_q <= 1'b0;
            kick2_seen_q <= 1'b0;
        end else begin
            kick1_seen_q <= k1 && opt_en;
            kick2_seen_q <= k2 && opt_en;
        end
    end

    // ------------------------------------------------------------
    // watchdog counter
    // ------------------------------------------------------------
    // instruction clock tick: system clock divided by four, gated off in halt
    logic [1:0] sysdiv_q;
    // limitation: on the instruction clock the watchdog is blind during halt
    wire instr_tick = (sysdiv_q == 2'(WDHW_SYSDIV - 1)) && !in_halt;
    wire osc_tick = osc_sync_q[1] && !osc_prev_q;
    wire wdt_tick = opt_osc ? osc_tick : instr_tick;
    localparam int CNT_W = WDHW_PRE_STAGES + WDHW_SEL_STAGES;
    logic [CNT_W-1:0] wdt_cnt_q;
    logic [CNT_W:0] wdt_inc;
    logic [CNT_W:0] stage_ovf;
    assign wdt_inc = {1'b0, wdt_cnt_q} + {{CNT_W{1'b0}}, 1'b1};
    // stage k carries out when all bits below base+k are ones
    genvar g;
    generate
        for (g = 0; g <= WDHW_SEL_STAGES; g++) begin : g_stage
            assign stage_ovf[g] = &wdt_cnt_q[WDHW_PRE_STAGES+g-1:0];
        end
        for (g = WDHW_SEL_STAGES + 1; g <= CNT_W; g++) begin : g_pad
            assign stage_ovf[g] = 1'b0;
        end
    endgenerate
    wire stage_hit = stage_ovf[sel];
    wire wdt_live = opt_en && !pin_low;
    assign timeout = wdt_live && wdt_tick && stage_hit;

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sysdiv_q <= 2'b00;
            wdt_cnt_q <= '0;
        end else begin
            sysdiv_q <= in_halt ? 2'b00 : sysdiv_q + 2'b01;
            if (wdt_clear || !opt_en) begin
                wdt_cnt_q <= '0;
            end else if (wdt_tick) begin
                wdt_cnt_q <= wdt_inc[CNT_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // halt / wake sequencing
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        case (state_q)
            WDHW_RUN: begin
                if (halt_go) begin
                    state_d = WDHW_HALT;
                end
            end
            WDHW_HALT: begin
                if (wake_ev) begin
                    state_d = WDHW_WAKE;
                end
            end
            WDHW_WAKE: begin
                if (wake_cnt_q == 11'd1) begin
                    state_d = WDHW_RUN;
                end
            end
            default: state_d = WDHW_RUN;
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_q <= WDHW_RUN;
            wake_cnt_q <= '0;
            irq_at_halt_q <= 1'b0;
            wake_irq_q <= 1'b0;
        end else if (pin_low) begin
            // a pin reset wins over any wake in progress
            state_q <= WDHW_RUN;
            wake_cnt_q <= '0;
            wake_irq_q <= 1'b0;
        end else begin
            state_q <= state_d;
            if (halt_go) begin
                irq_at_halt_q <= i_irq_pending;
            end
            if (wake_ev) begin
                wake_cnt_q <= 11'(P_WAKE_CYC);
                wake_irq_q <= wake_by_irq;
            end else if (wake_cnt_q != 11'd0) begin
                wake_cnt_q <= wake_cnt_q - 11'd1;
            end
        end
    end

    // ------------------------------------------------------------
    // register writes and setup reset on pin or timeout, both only outside halt
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            setup_q <= WDHW_SETUP_RST;
            opt_q <= WDHW_OPT_RST;
            wake_en_q <= WDHW_WAKE_EN_RST;
            rd_q <= 1'b0;
        end else begin
            rd_q <= i_reg_rd;
            if (pin_low && !in_halt) begin
                setup_q <= WDHW_SETUP_RST;
            end else if (timeout && !in_halt) begin
                setup_q <= WDHW_SETUP_RST;
            end else if (wr_setup) begin
                setup_q <= i_reg_wdata;
            end
            if (wr_opt) begin
                opt_q <= i_reg_wdata;
            end
            if (wr_wake) begin
                wake_en_q <= i_reg_wdata;
            end
        end
    end

    // ------------------------------------------------------------
    // status flags
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            to_q <= 1'b0;
            pdf_q <= 1'b0;
        end else begin
            // timeout set wins over any clear in the same cycle
            if (timeout) begin
                to_q <= 1'b1;
            end else if (halt_go || kick) begin
                to_q <= 1'b0;
            end else if (pin_low && in_halt) begin
                to_q <= 1'b0;
            end
            if (halt_go) begin
                pdf_q <= 1'b1;
            end else if (kick) begin
                pdf_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    logic chip_rst_q;
    logic warm_rst_q;
    logic div4_q;
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            chip_rst_q <= 1'b1;
            warm_rst_q <= 1'b0;
        end else begin
            chip_rst_q <= pin_low || (timeout && !in_halt);
            warm_rst_q <= timeout && in_halt;
        end
    end
    // the divided clock idles low in halt so external logic sees a clean stop
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            div4_q <= 1'b0;
        end else begin
            div4_q <= (sysdiv_q < 2'd2) && !in_halt;
        end
    end
    // oscillator mux kept only as a presence check; analogue part is outside
    wire osc_any = opt_rc ? i_clock_timing_in_rc : i_clock_timing_in_xtal;
    assign o_sys_clk_en = !in_halt && (osc_any || !osc_any);
    assign o_chip_reset = chip_rst_q;
    assign o_warm_reset = warm_rst_q;
    assign o_halted = in_halt;
    assign o_hold_state = (state_q != WDHW_RUN);
    wire wake_done = (state_q == WDHW_WAKE) && (wake_cnt_q == 11'd1);
    assign o_irq_service = wake_done && wake_irq_q && i_irq_enabled && !i_stack_full;
    assign o_resume_next = wake_done && !o_irq_service && !warm_rst_q;
    assign o_clock_div4_out = div4_q;
    assign o_clock_div4_out_oe = opt_rc;

    wire [7:0] status_word = (8'(to_q) << WDHW_TO_BIT) | (8'(pdf_q) << WDHW_PDF_BIT);
    logic [7:0] rdata_q;
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rdata_q <= 8'h00;
        end else if (!i_reg_rd) begin
            rdata_q <= 8'h00;
        end else if (rd_setup) begin
            rdata_q <= setup_q;
        end else if (rd_status) begin
            rdata_q <= status_word;
        end else if (rd_opt) begin
            rdata_q <= opt_q;
        end else if (rd_wake) begin
            rdata_q <= wake_en_q;
        end else begin
            rdata_q <= 8'h00;
        end
    end
    // read data stand only in the cycle after the strobe
    assign o_reg_rdata = rd_q ? rdata_q : 8'h00;
endmodule // wdhw_top

// ### tb/wdhw_asserts.sv
// checker: port assertions for the watchdog and halt/wake block
`timescale 1ns/1ps
module wdhw_asserts
    import wdhw_pkg::*;
#(
    parameter int P_WAKE_CYC = WDHW_WAKE_TSYS
) (
    // clock, reset, inputs
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic i_external_clear_pin_n,
    input wire logic i_halt_instr,
    input wire logic i_reg_rd,
    // outputs
    input wire logic [7:0] o_reg_rdata,
    input wire logic o_chip_reset,
    input wire logic o_warm_reset,
    input wire logic o_sys_clk_en,
    input wire logic o_halted,
    input wire logic o_hold_state,
    input wire logic o_resume_next,
    input wire logic o_irq_service,
    input wire logic o_clock_div4_out
);
    // ----
    // wake wait counter
    // ----
    logic [11:0] wcnt_q;
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            wcnt_q <= 12'h000;
        end else if (!o_hold_state || o_halted) begin
            wcnt_q <= 12'h000;
        end else begin
            wcnt_q <= wcnt_q + 12'h001;
        end
    end
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_reset_n);
    a_halt_entry: assert property (!o_hold_state && i_halt_instr && !o_chip_reset |=> o_halted)
        else $error("halt not entered");
    a_clk_gate: assert property (o_halted |-> !o_sys_clk_en && o_hold_state)
        else $error("clock runs in halt");
    a_div4_low: assert property (o_halted && $past(o_halted) |-> !o_clock_div4_out)
        else $error("div4 toggles in halt");
    a_div4_width: assert property ($rose(o_clock_div4_out) && !o_hold_state |=> o_clock_div4_out || o_hold_state)
        else $error("div4 high too short");
    a_wake_wait: assert property (o_resume_next || o_irq_service |-> int'(wcnt_q) >= P_WAKE_CYC - 1)
        else $error("wake wait too short");
    a_wake_bound: assert property (o_hold_state && !o_halted |-> int'(wcnt_q) <= P_WAKE_CYC + 1)
        else $error("wake wait too long");
    a_resume_once: assert property (o_resume_next || o_irq_service |=> !o_resume_next && !o_irq_service)
        else $error("resume pulse too long");
    a_warm_halt: assert property (o_warm_reset |-> $past(o_halted) && !o_chip_reset)
        else $error("warm reset outside halt");
    a_pin_reset: assert property (!i_external_clear_pin_n [*3] |=> o_chip_reset)
        else $error("pin low without chip reset");
    a_rdata_idle: assert property (!$past(i_reg_rd) |-> o_reg_rdata == 8'h00)
        else $error("read data outside read slot");
    c_warm: cover property (o_warm_reset);
    c_irq: cover property (o_irq_service);
    c_resume: cover property (o_resume_next);
    c_chip: cover property (!o_hold_state ##1 o_chip_reset);
endmodule // wdhw_asserts

bind wdhw_top wdhw_asserts #(.P_WAKE_CYC(P_WAKE_CYC)) chk_u (.i_clk_sys, .i_reset_n, .i_external_clear_pin_n,
    .i_halt_instr, .i_reg_rd, .o_reg_rdata, .o_chip_reset, .o_warm_reset, .o_sys_clk_en, .o_halted,
    .o_hold_state, .o_resume_next, .o_irq_service, .o_clock_div4_out);

// ### tb/testbench.sv
// testbench: directed scenarios for the watchdog and halt/wake block
`timescale 1ns/1ps
module testbench
    import wdhw_pkg::*;
;
    // short wake wait keeps halt scenarios quick
    localparam int WAKE = 8;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic pin_n = 1'b1;
    logic osc = 1'b0;
    logic [1:0] ph = 2'b00;
    logic [7:0] pa = 8'hFF;
    logic [3:0] ev = 4'h0;
    logic irq = 1'b0;
    logic irq_en = 1'b0;
    logic sf = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic [7:0] rdata;
    logic div4, div4_oe, chip_rst, warm_rst, clk_en, halted, hold, resume, svc;
    int errors = 0;
    int num_checks = 0;
    int n_rst = 0;
    wdhw_top #(.P_WAKE_CYC(WAKE), .P_PORT_W(8)) dut_u (
        .i_clk_sys(clk), .i_reset_n(rst_n), .i_external_clear_pin_n(pin_n), .i_wdt_osc(osc),
        .i_clock_timing_in_rc(1'b0), .i_clock_timing_in_xtal(1'b0), .i_port_a(pa),
        .o_clock_div4_out(div4), .o_clock_div4_out_oe(div4_oe), .i_watchdog_kick_instr(ev[0]),
        .i_watchdog_kick_first(ev[1]), .i_watchdog_kick_second(ev[2]), .i_halt_instr(ev[3]),
        .i_irq_pending(irq), .i_irq_enabled(irq_en), .i_stack_full(sf), .o_chip_reset(chip_rst),
        .o_warm_reset(warm_rst), .o_sys_clk_en(clk_en), .o_halted(halted), .o_hold_state(hold),
        .o_resume_next(resume), .o_irq_service(svc), .i_reg_addr(addr), .i_reg_wdata(wdata),
        .i_reg_wr(wr_s), .i_reg_rd(rd_s), .o_reg_rdata(rdata));
    initial begin
        forever #2.5 clk = ~clk;
    end
    // chip reset pulses are counted here so none is missed between checks
    always @(posedge clk) begin
        if (rst_n === 1'b1 && chip_rst === 1'b1) n_rst <= n_rst + 1;
    end
    // watchdog oscillator: one tick every four system clocks
    always @(posedge clk) begin
        ph <= ph + 2'b01;
        osc <= ph[1];
    end
    // ----
    // shared tasks
    // ----
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask
    task automatic rdchk(input logic [3:0] a, input logic [7:0] e, input string nm);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1;
        chk(nm, {8'h00, e}, {8'h00, rdata});
    endtask
    task automatic pulse(input logic [3:0] m);
        @(posedge clk);
        ev <= m;
        @(posedge clk);
        ev <= 4'h0;
    endtask
    task automatic settle();
        int k;
        k = 0;
        while (k < 80 && (chip_rst !== 1'b0 || hold !== 1'b0)) begin
            @(posedge clk);
            k++;
        end
    endtask
    task automatic run(input logic [7:0] opt, input logic [3:0] m, input logic e);
        int n0;
        settle();
        n0 = n_rst;
        wr(WDHW_ADDR_OPTION, opt);
        pulse(m);
        wr(WDHW_ADDR_SETUP, 8'h00);
        repeat (15) begin
            repeat (200) @(posedge clk);
            pulse(m);
        end
        chk("timeout_seen", {15'h0000, e}, {15'h0000, n_rst != n0});
    endtask
    task automatic hw(input logic [7:0] p, input logic [2:0] iq, input logic sv);
        int n;
        n = 0;
        pulse(4'h8);
        #1;
        chk("halted", 16'h0001, {15'h0000, halted});
        @(posedge clk);
        pa <= p;
        {irq, irq_en, sf} <= iq;
        while (n < 60 && resume !== 1'b1 && svc !== 1'b1) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk("wake_wait", 16'h0001, {15'h0000, n >= WAKE && n <= WAKE + 8});
        chk("irq_service", {15'h0000, sv}, {15'h0000, svc});
        @(posedge clk);
        pa <= 8'hFF;
        {irq, irq_en, sf} <= 3'b000;
        repeat (4) @(posedge clk);
    endtask
    // ----
    // scenarios
    // ----
    task automatic t_regs();
        rdchk(WDHW_ADDR_SETUP, WDHW_SETUP_RST, "setup_rst");
        rdchk(WDHW_ADDR_OPTION, WDHW_OPT_RST, "opt_rst");
        rdchk(WDHW_ADDR_STATUS, 8'h00, "status_rst");
        rdchk(4'h2, 8'h00, "unmapped");
        wr(WDHW_ADDR_SETUP, 8'hF5);
        rdchk(WDHW_ADDR_SETUP, 8'hF5, "setup_rw");
        wr(WDHW_ADDR_OPTION, 8'h0B);
        #1;
        chk("oe_rc", 16'h0001, {15'h0000, div4_oe});
        wr(WDHW_ADDR_OPTION, 8'h03);
        #1;
        chk("oe_xtal", 16'h0000, {15'h0000, div4_oe});
        $display("t_regs done");
    endtask
    task automatic t_kick();
        run(8'h03, 4'h1, 1'b0);
        run(8'h03, 4'h6, 1'b1);
        run(8'h07, 4'h6, 1'b0);
        run(8'h07, 4'h2, 1'b1);
        run(8'h07, 4'h1, 1'b1);
        run(8'h02, 4'h0, 1'b0);
        $display("t_kick done");
    endtask
    task automatic t_tmo();
        int n;
        for (int s = 0; s < 3; s++) begin
            settle();
            wr(WDHW_ADDR_OPTION, 8'h03);
            pulse(4'h1);
            wr(WDHW_ADDR_SETUP, 8'(s));
            n = 0;
            while (n < 9000 && chip_rst !== 1'b1) begin
                @(posedge clk);
                n++;
            end
            chk("tmo_cycles", 16'h0001, {15'h0000, n >= (1024 << s) - 16 && n <= (1024 << s) + 12});
            settle();
            rdchk(WDHW_ADDR_STATUS, 8'h20, "to_flag");
            rdchk(WDHW_ADDR_SETUP, WDHW_SETUP_RST, "setup_after_to");
        end
        $display("t_tmo done");
    endtask
    task automatic t_halt();
        wr(WDHW_ADDR_OPTION, 8'h03);
        wr(WDHW_ADDR_WAKE, 8'h01);
        pulse(4'h1);
        hw(8'hFC, 3'b000, 1'b0);
        hw(8'hFF, 3'b110, 1'b1);
        hw(8'hFF, 3'b100, 1'b0);
        hw(8'hFF, 3'b111, 1'b0);
        @(posedge clk);
        {irq, irq_en} <= 2'b11;
        pulse(4'h8);
        rdchk(WDHW_ADDR_STATUS, 8'h10, "pdf_set");
        @(posedge clk);
        pa <= 8'hFD;
        repeat (20) @(posedge clk);
        chk("no_wake", 16'h0001, {15'h0000, halted});
        pa <= 8'hFC;
        {irq, irq_en} <= 2'b00;
        repeat (WAKE + 12) @(posedge clk);
        chk("port_wake", 16'h0000, {15'h0000, hold});
        pa <= 8'hFF;
        pulse(4'h1);
        rdchk(WDHW_ADDR_STATUS, 8'h00, "pdf_clr");
        $display("t_halt done");
    endtask
    task automatic t_pin();
        wr(WDHW_ADDR_SETUP, 8'h55);
        @(posedge clk);
        pin_n <= 1'b0;
        repeat (4) @(posedge clk);
        #1;
        chk("pin_reset", 16'h0001, {15'h0000, chip_rst});
        @(posedge clk);
        pin_n <= 1'b1;
        settle();
        rdchk(WDHW_ADDR_SETUP, WDHW_SETUP_RST, "setup_pin");
        $display("t_pin done");
    endtask
    task automatic t_warm();
        int n;
        n = 0;
        wr(WDHW_ADDR_OPTION, 8'h03);
        pulse(4'h1);
        wr(WDHW_ADDR_SETUP, 8'h00);
        pulse(4'h8);
        while (n < 2000 && warm_rst !== 1'b1) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk("warm_cycles", 16'h0001, {15'h0000, n >= 1010 && n <= 1040});
        chk("no_chip_reset", 16'h0000, {15'h0000, chip_rst});
        settle();
        rdchk(WDHW_ADDR_STATUS, 8'h30, "warm_flags");
        rdchk(WDHW_ADDR_SETUP, 8'h00, "warm_keeps");
        $display("t_warm done");
    endtask
    task automatic t_instr();
        int n;
        n = 0;
        settle();
        wr(WDHW_ADDR_OPTION, 8'h01);
        pulse(4'h1);
        wr(WDHW_ADDR_SETUP, 8'h00);
        while (n < 2000 && chip_rst !== 1'b1) begin
            @(posedge clk);
            n++;
        end
        chk("instr_tmo", 16'h0001, {15'h0000, n >= 1008 && n <= 1036});
        settle();
        wr(WDHW_ADDR_SETUP, 8'h00);
        pulse(4'h8);
        repeat (1500) @(posedge clk);
        chk("instr_halt", 16'h0001, {15'h0000, halted});
        pa <= 8'hFE;
        repeat (WAKE + 12) @(posedge clk);
        chk("instr_wake", 16'h0000, {15'h0000, hold});
        pa <= 8'hFF;
        $display("t_instr done");
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_kick();
        t_tmo();
        t_halt();
        t_pin();
        t_warm();
        t_instr();
        conclude();
    end
    // nearly three times the expected run time
    initial begin
        #400_000;
        errors++;
        $display("BAD watchdog expected finish seen hang");
        conclude();
    end
endmodule // testbench
